// File: hdl/rosr_router.sv
// Rear panel output signal router with selection registers
// Behaviour
// - Each output connector has its own selector; a new code replaces the old.
// - Code zero drives no routed signal on that connector.
// - Any code is accepted; codes 32 and 33 show their source only while compressed mode is active.
// - Code 32 compressed frame indicator toggles only during compressed frames.
// - Code 4 routes the 3.84 MHz chip clock.
// - Code 5 routes frame number reset, code 6 frame number sync pulse.
// - Code 10 routes the synchronisation channel slot pulse.
// - Code 11 routes the 10 ms frame pulse, code 13 the 80 ms pulse.
// - Code 20 routes the data clock continuously, through transmission gaps.
// - Code 30 routes the data clock suppressed during transmission gaps.
// - With compressed mode off, code 30 equals code 20.
// - Codes 21, 22, 23 route power-control, combination indicator, pilot clocks.
// - Code 24 routes the bit stream before spreading and scrambling.
// - Code 25 routes the timeslot pulse, code 26 the frame pulse.
// - Code 28 routes the data bit clock.
// - Code 33 routes the transmission gap indicator.
// - Input connector function depends on compressed or out-of-sync mode; diversity is the default.
`timescale 1ns/1ns
`include "rosr_defines.svh"

module rosr_router
    import rosr_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter int SEL_W     = 6
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Internal sources and feature activity
    input  wire rosr_src_t            src_in,
    input  wire rosr_feat_t           feat_in,
    input  wire logic                 src_valid,
    output logic                      src_ready,
    // External reference clock pin (baseband_reference_input)
    input  wire logic                 baseband_reference_input,
    // Rear panel outputs
    output logic [NUM_PORTS-1:0]      port_out,
    output logic                      port_valid,
    input  wire logic                 port_ready,
    output logic [2:0]                input_fn,
    output logic                      ref_clk_sync
);

    // -------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------
    // Refused at elaboration, so a bad build never reaches simulation
    if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 4");
    end
    if (SEL_W != 6) begin : g_bad_sel
        $error("SEL_W must be 6");
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    logic [SEL_W-1:0] sel_r [NUM_PORTS];
    logic [2:0]       mode_r;
    logic [1:0]       ref_meta_r;

    // Selector writes; each port independent, newest code wins
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                sel_r[i] <= `ROSR_SEL_RESET;
            end
        end else if (reg_wr && reg_addr < 4'(NUM_PORTS)) begin
            sel_r[reg_addr[1:0]] <= reg_wdata[SEL_W-1:0];
        end
    end

    // Mode register steers the input connector function
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_r <= `ROSR_MODE_RESET;
        end else if (reg_wr && reg_addr == `ROSR_ADDR_MODE) begin
            mode_r <= reg_wdata[2:0];
        end
    end

    // -------------------------------------------------------------
    // Reference input synchroniser
    // -------------------------------------------------------------
    // External chip clock arrives asynchronously; sampled only as a level
    always_ff @(posedge clock) begin
        if (rst) begin
            ref_meta_r <= 2'h0;
        end else begin
            ref_meta_r <= {ref_meta_r[0], baseband_reference_input};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ref_clk_sync <= 1'b0;
        end else begin
            ref_clk_sync <= ref_meta_r[1];
        end
    end

    // -------------------------------------------------------------
    // Input connector function
    // -------------------------------------------------------------
    // Compressed mode outranks out-of-sync; diversity is the default
    always_ff @(posedge clock) begin
        if (rst) begin
            input_fn <= ROSR_IN_TXD;
        end else if (mode_r[`ROSR_MODE_CMP_BIT]) begin
            input_fn <= ROSR_IN_CMP;
        end else if (mode_r[`ROSR_MODE_OOS_BIT]) begin
            input_fn <= ROSR_IN_OOS;
        end else begin
            input_fn <= ROSR_IN_TXD;
        end
    end

    // -------------------------------------------------------------
    // Per-port selection
    // -------------------------------------------------------------
    // Feature active means mode enabled and feature reported running
    logic cmp_on;
    logic oos_on;
    logic txd_on;
    assign cmp_on = mode_r[`ROSR_MODE_CMP_BIT] & feat_in.cmp;
    assign oos_on = mode_r[`ROSR_MODE_OOS_BIT] & feat_in.oos;
    assign txd_on = mode_r[`ROSR_MODE_TXD_BIT] & feat_in.txd;

    logic [NUM_PORTS-1:0] route;

    // Each mux reads only its own selector, so edits stay local
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            always_comb begin
                case (sel_r[p])
                    `ROSR_CODE_NONE:      route[p] = 1'b0;
                    `ROSR_CODE_CHIP_CLK:  route[p] = src_in.chip_clk;
                    `ROSR_CODE_SFN_RST:   route[p] = src_in.sfn_reset;
                    `ROSR_CODE_SFN_SYNC:  route[p] = src_in.sfn_sync;
                    `ROSR_CODE_SCH_SLOT:  route[p] = src_in.sch_slot;
                    `ROSR_CODE_FRAME10:   route[p] = src_in.frame10;
                    `ROSR_CODE_FRAME80:   route[p] = src_in.frame80;
                    `ROSR_CODE_DCLK_CONT: route[p] = src_in.dpdch_clk;
                    `ROSR_CODE_PC_CLK:    route[p] = src_in.pc_clk;
                    `ROSR_CODE_FCI_CLK:   route[p] = src_in.fci_clk;
                    `ROSR_CODE_PILOT_CLK: route[p] = src_in.pilot_clk;
                    `ROSR_CODE_BITSTREAM: route[p] = src_in.bit_stream;
                    `ROSR_CODE_SLOT:      route[p] = src_in.slot_pulse;
                    `ROSR_CODE_DFRAME:    route[p] = src_in.dpch_frame;
                    `ROSR_CODE_DBIT_CLK:  route[p] = src_in.dpch_bit_clk;
                    // Gap suppression only bites in compressed mode
                    `ROSR_CODE_DCLK_GATE: route[p] = src_in.dpdch_clk & ~(cmp_on & src_in.gap);
                    `ROSR_CODE_CMP_FRAME: route[p] = cmp_on & src_in.cmp_frame;
                    `ROSR_CODE_GAP:       route[p] = cmp_on & src_in.gap;
                    default:              route[p] = 1'b0;
                endcase
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // Two-entry output buffer
    // -------------------------------------------------------------
    // Skid pair keeps every sample when the consumer stalls
    logic [NUM_PORTS-1:0] buf_r [2];
    logic [1:0]           cnt_r;
    logic                 rd_ptr_r;
    logic                 wr_ptr_r;
    logic                 push;
    logic                 pop;
    assign push = src_valid && src_ready;
    assign pop  = port_valid && port_ready;

    // Fill level and pointers
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r    <= 2'h0;
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
        end
    end

    // Storage written at the write pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end else if (push) begin
            buf_r[wr_ptr_r] <= route;
        end
    end

    // Registered handshake view of the next fill level
    logic [1:0] cnt_nxt;
    assign cnt_nxt = cnt_r + 2'(push) - 2'(pop);

    always_ff @(posedge clock) begin
        if (rst) begin
            src_ready  <= 1'b0;
            port_valid <= 1'b0;
        end else begin
            src_ready  <= (cnt_nxt != 2'h2);
            port_valid <= (cnt_nxt != 2'h0);
        end
    end

    // Output data register follows the head entry; idle reads low
    logic                 rd_ptr_nxt;
    logic [NUM_PORTS-1:0] head_nxt;
    assign rd_ptr_nxt = pop ? ~rd_ptr_r : rd_ptr_r;

    always_comb begin
        if (cnt_nxt == 2'h0) begin
            head_nxt = '0;
        end else if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
            head_nxt = route;
        end else begin
            head_nxt = buf_r[rd_ptr_nxt];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_out <= '0;
        end else begin
            port_out <= head_nxt;
        end
    end

    // -------------------------------------------------------------
    // Register read port
    // -------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `ROSR_ADDR_SEL0,
                `ROSR_ADDR_SEL1,
                `ROSR_ADDR_SEL2,
                `ROSR_ADDR_SEL3: begin
                    if (reg_addr < 4'(NUM_PORTS)) begin
                        reg_rdata <= {26'h0, sel_r[reg_addr[1:0]]};
                    end else begin
                        reg_rdata <= 32'h0;
                    end
                end
                `ROSR_ADDR_MODE:   reg_rdata <= {29'h0, mode_r};
                `ROSR_ADDR_STATUS: reg_rdata <= {24'h0, ref_clk_sync, cnt_r, cmp_on, oos_on, txd_on, 2'h0};
                default:           reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule

// File: inc/rosr_defines.svh
// Constants for the rear output signal router
`ifndef ROSR_DEFINES_SVH
`define ROSR_DEFINES_SVH

// -----------------------------------------------------------------
// Register map (plain port, word index)
// -----------------------------------------------------------------
`define ROSR_ADDR_SEL0      4'h0
`define ROSR_ADDR_SEL1      4'h1
`define ROSR_ADDR_SEL2      4'h2
`define ROSR_ADDR_SEL3      4'h3
`define ROSR_ADDR_MODE      4'h4
`define ROSR_ADDR_STATUS    4'h5

// -----------------------------------------------------------------
// Mode register fields and reset values
// -----------------------------------------------------------------
`define ROSR_MODE_CMP_BIT   0
`define ROSR_MODE_OOS_BIT   1
`define ROSR_MODE_TXD_BIT   2
`define ROSR_SEL_RESET      6'h00
`define ROSR_MODE_RESET     3'h0

// -----------------------------------------------------------------
// Selection codes
// -----------------------------------------------------------------
`define ROSR_CODE_NONE      6'h00
`define ROSR_CODE_CHIP_CLK  6'h04
`define ROSR_CODE_SFN_RST   6'h05
`define ROSR_CODE_SFN_SYNC  6'h06
`define ROSR_CODE_SCH_SLOT  6'h0A
`define ROSR_CODE_FRAME10   6'h0B
`define ROSR_CODE_FRAME80   6'h0D
`define ROSR_CODE_DCLK_CONT 6'h14
`define ROSR_CODE_PC_CLK    6'h15
`define ROSR_CODE_FCI_CLK   6'h16
`define ROSR_CODE_PILOT_CLK 6'h17
`define ROSR_CODE_BITSTREAM 6'h18
`define ROSR_CODE_SLOT      6'h19
`define ROSR_CODE_DFRAME    6'h1A
`define ROSR_CODE_DBIT_CLK  6'h1C
`define ROSR_CODE_DCLK_GATE 6'h1E
`define ROSR_CODE_CMP_FRAME 6'h20
`define ROSR_CODE_GAP       6'h21

`endif

// File: inc/rosr_pkg.sv
// Types shared by the rear output signal router
package rosr_pkg;

    // Internal timing and data sources presented to the router
    typedef struct packed {
        logic chip_clk;
        logic sfn_reset;
        logic sfn_sync;
        logic sch_slot;
        logic frame10;
        logic frame80;
        logic dpdch_clk;
        logic pc_clk;
        logic fci_clk;
        logic pilot_clk;
        logic bit_stream;
        logic slot_pulse;
        logic dpch_frame;
        logic dpch_bit_clk;
        logic cmp_frame;
        logic gap;
    } rosr_src_t;

    // Feature activity flags
    typedef struct packed {
        logic txd;
        logic oos;
        logic cmp;
    } rosr_feat_t;

    // Input connector functions
    typedef enum logic [2:0] {
        ROSR_IN_TXD = 3'b001,
        ROSR_IN_CMP = 3'b010,
        ROSR_IN_OOS = 3'b100
    } rosr_in_fn_t;

endpackage

// File: verif/rosr_equip_model.sv
// Behavioural test equipment on the rear panel connectors
`timescale 1ns/1ns
module rosr_equip_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Pace: 0 prompt, 1 random stalls, 2 hold off
    input  wire logic [1:0] pace,
    // Panel side
    output logic            port_ready,
    output logic            ref_in
);
    initial port_ready = 1'b0;
    initial ref_in = 1'b0;
    // Consumer takes words at the pace the bench picks
    always @(posedge clock) begin
        if (rst)
            port_ready <= 1'b0;
        else
            port_ready <= (pace == 2'h0) || (pace == 2'h1 && $urandom_range(1, 0) == 1);
    end
    // Chip clock on the reference pin; moves on the falling edge so it never races sampling
    always @(negedge clock) begin
        if ($urandom_range(2, 0) == 0)
            ref_in <= ~ref_in;
    end
endmodule

// File: verif/rosr_router_properties.sv
// Port-level checker for the rear output signal router
`timescale 1ns/1ns
module rosr_router_properties
    import rosr_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rst,
    // Register port
    input wire logic [3:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // Stream and pins
    input wire rosr_src_t            src_in,
    input wire rosr_feat_t           feat_in,
    input wire logic                 src_valid,
    input wire logic                 src_ready,
    input wire logic                 baseband_reference_input,
    input wire logic [NUM_PORTS-1:0] port_out,
    input wire logic                 port_valid,
    input wire logic                 port_ready,
    input wire logic [2:0]           input_fn,
    input wire logic                 ref_clk_sync
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles since release; synchroniser history is junk for the first few
    logic [2:0] up_r;
    always_ff @(posedge clock) begin
        if (rst)
            up_r <= 3'h0;
        else if (up_r != 3'h7)
            up_r <= up_r + 3'h1;
    end
    property p_rdata_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
    property p_sel_back;
        reg_wr && reg_addr < 4'(NUM_PORTS) ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
            |=> reg_rdata == {26'h0, $past(reg_wdata[5:0], 3)};
    endproperty
    a_sel_back: assert property (p_sel_back) else $error("selector readback");
    property p_mode_back;
        reg_wr && reg_addr == 4'h4 ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h4
            |=> reg_rdata == {29'h0, $past(reg_wdata[2:0], 3)};
    endproperty
    a_mode_back: assert property (p_mode_back) else $error("mode readback");
    property p_unmapped; reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_hold; port_valid && !port_ready |=> port_valid && $stable(port_out); endproperty
    a_hold: assert property (p_hold) else $error("output dropped in stall");
    property p_push; src_valid && src_ready && !port_valid |=> port_valid; endproperty
    a_push: assert property (p_push) else $error("push not presented");
    property p_ref; up_r >= 3'h4 |-> ref_clk_sync == $past(baseband_reference_input, 3); endproperty
    a_ref: assert property (p_ref) else $error("reference sync latency");
    // Input function follows the mode register two edges after the write
    property p_fn_idle;
        reg_wr && reg_addr == 4'h4 && reg_wdata[1:0] == 2'h0 |=> ##1 input_fn == 3'b001;
    endproperty
    a_fn_idle: assert property (p_fn_idle) else $error("input function idle");
    property p_fn_cmp;
        reg_wr && reg_addr == 4'h4 && reg_wdata[0] |=> ##1 input_fn == 3'b010;
    endproperty
    a_fn_cmp: assert property (p_fn_cmp) else $error("input function compressed");
    c_stall: cover property (port_valid && !port_ready ##1 !src_ready);
    c_cmp_fn: cover property (input_fn == 3'b010);
    c_sel_rd: cover property (reg_rd && reg_addr < 4'h4);
endmodule
bind rosr_router rosr_router_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in), .feat_in(feat_in),
    .src_valid(src_valid), .src_ready(src_ready), .baseband_reference_input(baseband_reference_input),
    .port_out(port_out), .port_valid(port_valid), .port_ready(port_ready), .input_fn(input_fn),
    .ref_clk_sync(ref_clk_sync)
);

// File: verif/test_rosr_router.sv
// Self-checking bench for the rear output signal router
`timescale 1ns/1ns
module test_rosr_router;
    import rosr_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        src_valid = 1'b0;
    logic        src_ready, port_valid, port_ready, ref_in, ref_clk_sync;
    rosr_src_t   src_in = '0;
    rosr_feat_t  feat_in = '0;
    logic [3:0]  port_out, w;
    logic [2:0]  input_fn, fn_exp, mode_m, ref_h;
    int          up_m = 0;
    logic [1:0]  pace = 2'h0;
    logic [5:0]  sel_m [4];
    logic [3:0]  q [$];
    int          err_total = 0;
    int          n_tests = 0;
    // Codes in source struct order, chip clock first
    logic [5:0]  src_code [16] = '{6'h04, 6'h05, 6'h06, 6'h0A, 6'h0B, 6'h0D, 6'h14, 6'h15,
                                   6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1C, 6'h20, 6'h21};
    initial forever #25 clock = ~clock;
    rosr_router u_dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in), .feat_in(feat_in),
        .src_valid(src_valid), .src_ready(src_ready), .baseband_reference_input(ref_in),
        .port_out(port_out), .port_valid(port_valid), .port_ready(port_ready),
        .input_fn(input_fn), .ref_clk_sync(ref_clk_sync)
    );
    rosr_equip_model u_equip (.clock(clock), .rst(rst), .pace(pace), .port_ready(port_ready), .ref_in(ref_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check(reg_rdata, e);
    endtask
    // Reference routing; unknown and zero codes give a steady low
    function automatic logic route(input rosr_src_t s, input logic [5:0] c, input logic ca);
        route = 1'b0;
        if (c == 6'h1E)
            route = s.dpdch_clk & ~(ca & s.gap);
        for (int b = 0; b < 16; b++) begin
            if (c == src_code[b])
                route = s[15-b] & (b < 14 || ca);
        end
    endfunction
    function automatic logic [5:0] code_of(input int k);
        return k < 16 ? src_code[k] : k == 16 ? 6'h00 : k == 17 ? 6'h1E : 6'h07;
    endfunction
    // Model tracks writes and pushes, checks every delivered word
    always @(posedge clock) begin
        if (rst) begin
            q.delete();
            mode_m = 3'h0;
            sel_m = '{default: 6'h00};
            fn_exp = 3'b001;
            ref_h = 3'h0;
            up_m = 0;
        end else begin
            check(32'(input_fn), 32'(fn_exp));
            fn_exp = mode_m[0] ? 3'b010 : mode_m[1] ? 3'b100 : 3'b001;
            check(32'(ref_clk_sync), 32'(ref_h[2]));
            ref_h = {ref_h[1:0], ref_in};
            // Handshake flags mirror the model's fill level; skip the edge right after reset
            if (up_m > 0)
                check(32'({port_valid, src_ready}), 32'({q.size() != 0, q.size() != 2}));
            up_m++;
            if (port_valid && port_ready)
                check(32'(port_out), 32'(q.pop_front()));
            if (src_valid && src_ready) begin
                for (int i = 0; i < 4; i++)
                    w[i] = route(src_in, sel_m[i], mode_m[0] & feat_in.cmp);
                q.push_back(w);
            end
            if (reg_wr && reg_addr < 4'h4)
                sel_m[reg_addr[1:0]] = reg_wdata[5:0];
            if (reg_wr && reg_addr == 4'h4)
                mode_m = reg_wdata[2:0];
        end
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize();
    end
    initial begin
        logic [31:0] d;
        void'($urandom(32'h4222));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            d = $urandom;
            wr(4'(a), d);
            rd(4'(a), a < 4 ? {26'h0, d[5:0]} : {29'h0, d[2:0]});
        end
        wr(4'hC, $urandom);
        rd(4'h0, {26'h0, sel_m[0]});
        rd(4'hE, 32'h0);
        // Every code on every connector, stalls and feature flags varied
        for (int k = 0; k < 19; k++) begin
            for (int p = 0; p < 4; p++)
                wr(4'(p), {26'h0, code_of((k + p) % 19)});
            wr(4'h4, $urandom);
            pace <= 2'(k % 3);
            repeat (40) begin
                @(posedge clock);
                src_valid <= $urandom_range(3, 0) != 0;
                src_in <= rosr_src_t'($urandom);
                feat_in <= rosr_feat_t'($urandom);
            end
        end
        src_valid <= 1'b0;
        pace <= 2'h0;
        repeat (12) @(posedge clock);
        check(32'(q.size()), 32'h0);
        summarize();
    end
endmodule
